// >>> logic/backlight_boost_sync_config.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "backlight_consts.svh"

//Behaviour
// - sync enable bit lets PLL follow frame input
// - dither code gives zero to three bits
// - boost volts are ten plus code, capped forty
// - adaptive mode uses boost field as start
// - fixed mode uses boost field as target
// - byte six holds divider bits twelve to five
// - divider used only while sync enabled
// - byte seven top five bits are divider low
// - resolution bits pick PLL output frequency
module backlight_boost_sync_config (
   input  wire logic                     clk_sys_in,
   input  wire logic                     rstn_in,
   input  wire backlight_pkg::axil_req_t axil_req_in,
   output backlight_pkg::axil_rsp_t      axil_rsp_out,
   output logic                          config_ready_out,
   output logic                          sync_enable_out,
   output logic [1:0]                    dither_bits_out,
   output logic                          adaptive_boost_out,
   output logic [`VOLTS_W-1:0]           boost_start_volts_out,
   output logic [`VOLTS_W-1:0]           boost_fixed_volts_out,
   output logic [`DIV_W-1:0]             pll_divider_out,
   output logic [1:0]                    pll_freq_sel_out,
   output logic [`VOLTS_W-1:0]           pll_freq_mhz_out
);

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   // shared by the write and read paths so both agree on the map
   function automatic backlight_pkg::reg_sel_t reg_decode(input logic [`AXI_ADDR_W-1:0] addr);
      backlight_pkg::reg_sel_t sel;
      sel = backlight_pkg::SEL_NONE;
      if (addr[`AXI_ADDR_W-1:`REG_IDX_MSB+1] == `REG_PAGE_ZERO) begin
         case (addr[`REG_IDX_MSB:`REG_IDX_LSB])
            `REG_IDX_CTRL:     sel = backlight_pkg::SEL_CTRL;
            `REG_IDX_STATUS:   sel = backlight_pkg::SEL_STATUS;
            `REG_IDX_SYNC_CFG: sel = backlight_pkg::SEL_SYNC_CFG;
            `REG_IDX_DIV_HIGH: sel = backlight_pkg::SEL_DIV_HIGH;
            `REG_IDX_DIV_LOW:  sel = backlight_pkg::SEL_DIV_LOW;
            default:           sel = backlight_pkg::SEL_NONE;
         endcase
      end
      return sel;
   endfunction : reg_decode

   // ----------------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------------
   backlight_pkg::reg_req_t reg_req;
   backlight_pkg::reg_rsp_t reg_rsp;

   axil_reg_port u_port (
      .clk_sys_in   (clk_sys_in),
      .rstn_in      (rstn_in),
      .axil_req_in  (axil_req_in),
      .reg_rsp_in   (reg_rsp),
      .axil_rsp_out (axil_rsp_out),
      .reg_req_out  (reg_req)
   );

   // ----------------------------------------------------------------------
   // configuration storage
   // ----------------------------------------------------------------------
   logic [7:0] ctrl_reg,     ctrl_next;
   logic [7:0] sync_cfg_reg, sync_cfg_next;
   logic [7:0] div_high_reg, div_high_next;
   logic [7:0] div_low_reg,  div_low_next;
   backlight_pkg::reg_sel_t wr_sel;
   backlight_pkg::reg_sel_t rd_sel;

   assign wr_sel = reg_decode(reg_req.wr_addr);
   assign rd_sel = reg_decode(reg_req.rd_addr);

   // software writes land here; status is read-only and drops writes
   always_comb begin
      ctrl_next     = ctrl_reg;
      sync_cfg_next = sync_cfg_reg;
      div_high_next = div_high_reg;
      div_low_next  = div_low_reg;
      if (reg_req.wr_en) begin
         case (wr_sel)
            backlight_pkg::SEL_CTRL:     ctrl_next     = reg_req.wr_data & `CTRL_WR_MASK;
            backlight_pkg::SEL_SYNC_CFG: sync_cfg_next = reg_req.wr_data;
            backlight_pkg::SEL_DIV_HIGH: div_high_next = reg_req.wr_data;
            backlight_pkg::SEL_DIV_LOW:  div_low_next  = reg_req.wr_data;
            default:                     ctrl_next     = ctrl_reg;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_reg     <= `CTRL_RESET;
         sync_cfg_reg <= `CFG_RESET;
         div_high_reg <= `CFG_RESET;
         div_low_reg  <= `CFG_RESET;
      end else begin
         ctrl_reg     <= ctrl_next;
         sync_cfg_reg <= sync_cfg_next;
         div_high_reg <= div_high_next;
         div_low_reg  <= div_low_next;
      end
   end

   // ----------------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------------
   logic                loaded;
   logic                adaptive;
   logic [4:0]          boost_code;
   logic [4:0]          boost_capped;
   logic [`VOLTS_W-1:0] boost_volts;
   logic [`DIV_W-1:0]   div_count;
   logic [1:0]          res_sel;

   assign loaded   = ctrl_reg[`CTRL_LOADED_BIT];
   assign adaptive = ctrl_reg[`CTRL_ADAPTIVE_BIT];
   assign res_sel  = ctrl_reg[`CTRL_RES_MSB:`CTRL_RES_LSB];

   // codes above the ceiling saturate rather than wrap past forty volts
   always_comb begin
      boost_code   = sync_cfg_reg[`BOOST_MSB:`BOOST_LSB];
      boost_capped = (boost_code > `BOOST_MAX_CODE) ? `BOOST_MAX_CODE : boost_code;
      boost_volts  = `BOOST_BASE_VOLTS + {1'b0, boost_capped};
   end

   // high byte on top, five low bits from byte seven below it
   assign div_count = {div_high_reg, div_low_reg[`DIV_LOW_MSB:`DIV_LOW_LSB]};

   // ----------------------------------------------------------------------
   // decoded outputs
   // ----------------------------------------------------------------------
   logic                ready_reg,      ready_next;
   logic                sync_reg,       sync_next;
   logic [1:0]          dither_reg,     dither_next;
   logic                adapt_reg,      adapt_next;
   logic [`VOLTS_W-1:0] start_reg,      start_next;
   logic [`VOLTS_W-1:0] fixed_reg,      fixed_next;
   logic [`DIV_W-1:0]   divider_reg,    divider_next;
   logic [1:0]          freq_sel_reg,   freq_sel_next;
   logic [`VOLTS_W-1:0] freq_mhz_reg,   freq_mhz_next;

   // every output except the PLL select and frequency reads zero until software
   // marks the configuration loaded, so downstream control never acts on a half-written set of fields
   always_comb begin
      ready_next    = loaded;
      sync_next     = loaded & sync_cfg_reg[`SYNC_EN_BIT];
      dither_next   = loaded ? sync_cfg_reg[`DITHER_MSB:`DITHER_LSB] : 2'h0;
      adapt_next    = loaded & adaptive;
      start_next    = (loaded && adaptive) ? boost_volts : '0;
      fixed_next    = (loaded && !adaptive) ? boost_volts : '0;
      divider_next  = sync_next ? div_count : '0;
      freq_sel_next = res_sel;
      freq_mhz_next = `PLL_BASE_MHZ << res_sel;
   end

   // held in flops so the consumers see glitch-free static levels
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ready_reg    <= 1'b0;
         sync_reg     <= 1'b0;
         dither_reg   <= 2'h0;
         adapt_reg    <= 1'b0;
         start_reg    <= '0;
         fixed_reg    <= '0;
         divider_reg  <= '0;
         freq_sel_reg <= 2'h0;
         freq_mhz_reg <= `PLL_BASE_MHZ;
      end else begin
         ready_reg    <= ready_next;
         sync_reg     <= sync_next;
         dither_reg   <= dither_next;
         adapt_reg    <= adapt_next;
         start_reg    <= start_next;
         fixed_reg    <= fixed_next;
         divider_reg  <= divider_next;
         freq_sel_reg <= freq_sel_next;
         freq_mhz_reg <= freq_mhz_next;
      end
   end

   assign config_ready_out      = ready_reg;
   assign sync_enable_out       = sync_reg;
   assign dither_bits_out       = dither_reg;
   assign adaptive_boost_out    = adapt_reg;
   assign boost_start_volts_out = start_reg;
   assign boost_fixed_volts_out = fixed_reg;
   assign pll_divider_out       = divider_reg;
   assign pll_freq_sel_out      = freq_sel_reg;
   assign pll_freq_mhz_out      = freq_mhz_reg;

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   // status reflects the presented outputs, so it lags a write by one cycle
   always_comb begin
      reg_rsp.wr_hit  = (wr_sel != backlight_pkg::SEL_NONE);
      reg_rsp.rd_hit  = (rd_sel != backlight_pkg::SEL_NONE);
      reg_rsp.rd_data = `AXI_DATA_ZERO;
      case (rd_sel)
         backlight_pkg::SEL_CTRL:     reg_rsp.rd_data[7:0] = ctrl_reg;
         backlight_pkg::SEL_SYNC_CFG: reg_rsp.rd_data[7:0] = sync_cfg_reg;
         backlight_pkg::SEL_DIV_HIGH: reg_rsp.rd_data[7:0] = div_high_reg;
         backlight_pkg::SEL_DIV_LOW:  reg_rsp.rd_data[7:0] = div_low_reg;
         backlight_pkg::SEL_STATUS: begin
            reg_rsp.rd_data[`STAT_VOLTS_MSB:0]            = adapt_reg ? start_reg : fixed_reg;
            reg_rsp.rd_data[`STAT_SYNC_BIT]               = sync_reg;
            reg_rsp.rd_data[`STAT_ADAPT_BIT]              = adapt_reg;
            reg_rsp.rd_data[`STAT_DIV_MSB:`STAT_DIV_LSB]  = divider_reg;
            reg_rsp.rd_data[`STAT_READY_BIT]              = ready_reg;
         end
         default:                     reg_rsp.rd_data = `AXI_DATA_ZERO;
      endcase
   end

endmodule : backlight_boost_sync_config

// >>> logic/backlight_consts.svh
`ifndef BACKLIGHT_CONSTS_SVH
`define BACKLIGHT_CONSTS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define AXI_ADDR_W          12
`define AXI_DATA_W          32
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2
`define AXI_DATA_ZERO       32'h0000_0000

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define REG_IDX_CTRL        8'h00
`define REG_IDX_STATUS      8'h01
`define REG_IDX_SYNC_CFG    8'hA5
`define REG_IDX_DIV_HIGH    8'hA6
`define REG_IDX_DIV_LOW     8'hA7
`define REG_IDX_MSB         9
`define REG_IDX_LSB         2
`define REG_PAGE_ZERO       2'h0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CFG_RESET           8'h00
`define CTRL_RESET          8'h00
`define CTRL_WR_MASK        8'h0F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_ADAPTIVE_BIT   0
`define CTRL_RES_MSB        2
`define CTRL_RES_LSB        1
`define CTRL_LOADED_BIT     3
`define SYNC_EN_BIT         7
`define DITHER_MSB          6
`define DITHER_LSB          5
`define BOOST_MSB           4
`define BOOST_LSB           0
`define DIV_LOW_MSB         7
`define DIV_LOW_LSB         3
`define STAT_VOLTS_MSB      5
`define STAT_SYNC_BIT       6
`define STAT_ADAPT_BIT      7
`define STAT_DIV_MSB        20
`define STAT_DIV_LSB        8
`define STAT_READY_BIT      21

// ----------------------------------------------------------------------
// decode figures
// ----------------------------------------------------------------------
`define BOOST_BASE_VOLTS    6'h0A
`define BOOST_MAX_CODE      5'h1E
`define PLL_BASE_MHZ        6'h05
`define DIV_W               13
`define VOLTS_W             6

`endif

// >>> logic/backlight_pkg.sv
`include "backlight_consts.svh"

package backlight_pkg;

   // ----------------------------------------------------------------------
   // axi4-lite channels, master to slave and back
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                    awvalid;
      logic [`AXI_ADDR_W-1:0]  awaddr;
      logic                    wvalid;
      logic [`AXI_DATA_W-1:0]  wdata;
      logic [3:0]              wstrb;
      logic                    bready;
      logic                    arvalid;
      logic [`AXI_ADDR_W-1:0]  araddr;
      logic                    rready;
   } axil_req_t;

   typedef struct packed {
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [`AXI_DATA_W-1:0]  rdata;
      logic [1:0]              rresp;
   } axil_rsp_t;

   // ----------------------------------------------------------------------
   // internal register access between bus port and register bank
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                    wr_en;
      logic [`AXI_ADDR_W-1:0]  wr_addr;
      logic [7:0]              wr_data;
      logic [`AXI_ADDR_W-1:0]  rd_addr;
   } reg_req_t;

   typedef struct packed {
      logic                    wr_hit;
      logic                    rd_hit;
      logic [`AXI_DATA_W-1:0]  rd_data;
   } reg_rsp_t;

   typedef enum logic [2:0] {
      SEL_NONE     = 3'h0,
      SEL_CTRL     = 3'h1,
      SEL_STATUS   = 3'h2,
      SEL_SYNC_CFG = 3'h3,
      SEL_DIV_HIGH = 3'h4,
      SEL_DIV_LOW  = 3'h5
   } reg_sel_t;

endpackage : backlight_pkg

// >>> logic/axil_reg_port.sv
`timescale 1ns/1ps
`include "backlight_consts.svh"

module axil_reg_port (
   input  wire logic                   clk_sys_in,
   input  wire logic                   rstn_in,
   input  wire backlight_pkg::axil_req_t axil_req_in,
   input  wire backlight_pkg::reg_rsp_t  reg_rsp_in,
   output backlight_pkg::axil_rsp_t    axil_rsp_out,
   output backlight_pkg::reg_req_t     reg_req_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic                   aw_full_reg,  aw_full_next;
   logic                   w_full_reg,   w_full_next;
   logic [`AXI_ADDR_W-1:0] aw_addr_reg,  aw_addr_next;
   logic [7:0]             w_data_reg,   w_data_next;
   logic                   w_strb_reg,   w_strb_next;
   logic                   awready_reg,  awready_next;
   logic                   wready_reg,   wready_next;
   logic                   arready_reg,  arready_next;
   logic                   bvalid_reg,   bvalid_next;
   logic [1:0]             bresp_reg,    bresp_next;
   logic                   rvalid_reg,   rvalid_next;
   logic [`AXI_DATA_W-1:0] rdata_reg,    rdata_next;
   logic [1:0]             rresp_reg,    rresp_next;
   logic                   do_write;

   // write fires only once both halves are held and no response is pending
   assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;

   // only the low byte lane carries register data; other lanes are dropped
   assign reg_req_out.wr_en   = do_write & w_strb_reg;
   assign reg_req_out.wr_addr = aw_addr_reg;
   assign reg_req_out.wr_data = w_data_reg;
   assign reg_req_out.rd_addr = axil_req_in.araddr;

   // ----------------------------------------------------------------------
   // channel next-state
   // ----------------------------------------------------------------------
   always_comb begin
      aw_full_next = aw_full_reg;
      w_full_next  = w_full_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (bvalid_reg && axil_req_in.bready) begin
         bvalid_next = 1'b0;
      end
      if (do_write) begin
         bvalid_next  = 1'b1;
         bresp_next   = reg_rsp_in.wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
      end
      if (axil_req_in.awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         aw_addr_next = axil_req_in.awaddr;
      end
      if (axil_req_in.wvalid && wready_reg) begin
         w_full_next = 1'b1;
         w_data_next = axil_req_in.wdata[7:0];
         w_strb_next = axil_req_in.wstrb[0];
      end
      if (rvalid_reg && axil_req_in.rready) begin
         rvalid_next = 1'b0;
      end
      if (axil_req_in.arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rdata_next  = reg_rsp_in.rd_hit ? reg_rsp_in.rd_data : `AXI_DATA_ZERO;
         rresp_next  = reg_rsp_in.rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      // readies are registered so every bus output leaves a flip-flop
      awready_next = ~aw_full_next & ~bvalid_next;
      wready_next  = ~w_full_next & ~bvalid_next;
      arready_next = ~rvalid_next;
   end

   // registers
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         arready_reg <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `AXI_RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= `AXI_DATA_ZERO;
         rresp_reg   <= `AXI_RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         arready_reg <= arready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   assign axil_rsp_out.awready = awready_reg;
   assign axil_rsp_out.wready  = wready_reg;
   assign axil_rsp_out.bvalid  = bvalid_reg;
   assign axil_rsp_out.bresp   = bresp_reg;
   assign axil_rsp_out.arready = arready_reg;
   assign axil_rsp_out.rvalid  = rvalid_reg;
   assign axil_rsp_out.rdata   = rdata_reg;
   assign axil_rsp_out.rresp   = rresp_reg;

endmodule : axil_reg_port

// >>> testbench/backlight_boost_sync_config_checker.sv
`timescale 1ns/1ps
`include "backlight_consts.svh"

module backlight_boost_sync_config_checker (
   input  wire logic                     clk_sys_in,
   input  wire logic                     rstn_in,
   input  wire backlight_pkg::axil_rsp_t axil_rsp_out,
   input  wire logic                     config_ready_out,
   input  wire logic                     sync_enable_out,
   input  wire logic [1:0]               dither_bits_out,
   input  wire logic                     adaptive_boost_out,
   input  wire logic [`VOLTS_W-1:0]      boost_start_volts_out,
   input  wire logic [`VOLTS_W-1:0]      boost_fixed_volts_out,
   input  wire logic [`DIV_W-1:0]        pll_divider_out,
   input  wire logic [1:0]               pll_freq_sel_out,
   input  wire logic [`VOLTS_W-1:0]      pll_freq_mhz_out
);
   // --------
   // decoded output relations, one clock domain
   // --------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);

   a_div_gated: assert property (!sync_enable_out |-> pll_divider_out == 13'h0000)
      else $error("divider shown while sync is off");
   a_freq_select: assert property (pll_freq_mhz_out == (6'h05 << pll_freq_sel_out))
      else $error("pll frequency does not follow select");
   a_volts_span: assert property ((boost_start_volts_out | boost_fixed_volts_out) != 6'h00
      |-> (boost_start_volts_out | boost_fixed_volts_out) inside {[6'h0A:6'h28]})
      else $error("boost volts outside ten to forty");
   a_start_adaptive: assert property (boost_start_volts_out != 6'h00 |-> adaptive_boost_out && config_ready_out)
      else $error("start volts shown outside adaptive mode");
   a_fixed_mode: assert property (boost_fixed_volts_out != 6'h00 |-> !adaptive_boost_out && config_ready_out)
      else $error("fixed volts shown in adaptive mode");
   a_one_target: assert property (config_ready_out |-> (boost_start_volts_out != 6'h00)
      != (boost_fixed_volts_out != 6'h00))
      else $error("boost target not exactly one of start or fixed");
   a_unloaded_quiet: assert property (!config_ready_out |-> !adaptive_boost_out
      && dither_bits_out == 2'h0 && boost_fixed_volts_out == 6'h00)
      else $error("decoded outputs active before load");
   a_sync_loaded: assert property (sync_enable_out |-> config_ready_out)
      else $error("sync enable without loaded configuration");
   // outputs move only just after a write
   a_static_outputs: assert property (!$past(axil_rsp_out.bvalid) |-> $stable({config_ready_out,
      sync_enable_out, dither_bits_out, adaptive_boost_out, boost_start_volts_out,
      boost_fixed_volts_out, pll_divider_out, pll_freq_sel_out}))
      else $error("decoded outputs moved without a write");

   c_sync_div: cover property (sync_enable_out && pll_divider_out != 13'h0000);
   c_start_top: cover property (boost_start_volts_out == 6'h28);
   c_dither_max: cover property (dither_bits_out == 2'h3);
endmodule : backlight_boost_sync_config_checker

bind backlight_boost_sync_config backlight_boost_sync_config_checker u_checker (
   .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .axil_rsp_out(axil_rsp_out),
   .config_ready_out(config_ready_out), .sync_enable_out(sync_enable_out), .dither_bits_out(dither_bits_out),
   .adaptive_boost_out(adaptive_boost_out), .boost_start_volts_out(boost_start_volts_out),
   .boost_fixed_volts_out(boost_fixed_volts_out), .pll_divider_out(pll_divider_out),
   .pll_freq_sel_out(pll_freq_sel_out), .pll_freq_mhz_out(pll_freq_mhz_out));

// >>> testbench/backlight_boost_sync_config_tb.sv
`timescale 1ns/1ps
`include "backlight_consts.svh"

module backlight_boost_sync_config_tb;
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STAT = 12'h004;
   localparam logic [11:0] A_SYNC = 12'h294;
   localparam logic [11:0] A_DIVH = 12'h298;
   localparam logic [11:0] A_DIVL = 12'h29C;
   logic                     clk_sys_in;
   logic                     rstn_in;
   backlight_pkg::axil_req_t req;
   backlight_pkg::axil_rsp_t rsp;
   logic                     ready, sync, adapt;
   logic [1:0]               dith, sel;
   logic [5:0]               vstart, vfixed, mhz;
   logic [12:0]              div;
   int                       n_fail;
   int                       n_compared;
   logic [31:0]              lfsr;

   // --------
   // clock, reset and design
   // --------
   always #2 clk_sys_in = ~clk_sys_in;

   backlight_boost_sync_config u_backlight_boost_sync_config (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .axil_req_in(req), .axil_rsp_out(rsp),
      .config_ready_out(ready), .sync_enable_out(sync), .dither_bits_out(dith), .adaptive_boost_out(adapt),
      .boost_start_volts_out(vstart), .boost_fixed_volts_out(vfixed), .pll_divider_out(div),
      .pll_freq_sel_out(sel), .pll_freq_mhz_out(mhz));

   // --------
   // helpers
   // --------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   // codes past thirty clamp at the forty volt ceiling
   function automatic logic [5:0] exp_volts(input logic [4:0] code);
      return (code >= 5'h1E) ? 6'h28 : 6'h0A + {1'b0, code};
   endfunction : exp_volts

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // aw and w offered together, bready held to the response
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk_sys_in);
      req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= s;
      req.bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk_sys_in);
         if (!aw && rsp.awready === 1'b1) begin aw = 1'b1; req.awvalid <= 1'b0; end
         if (!w && rsp.wready === 1'b1) begin w = 1'b1; req.wvalid <= 1'b0; end
      end
      while (rsp.bvalid !== 1'b1) @(posedge clk_sys_in);
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_sys_in);
      req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
      do @(posedge clk_sys_in); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      while (rsp.rvalid !== 1'b1) @(posedge clk_sys_in);
      d = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask : axi_read

   task automatic summarize();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   // --------
   // watchdog, run needs under ten thousand cycles
   // --------
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      summarize();
   end

   // --------
   // main sequence
   // --------
   initial begin
      logic [31:0] d, cw, st;
      logic [1:0]  r;
      logic [7:0]  s, h, l, c;
      logic [5:0]  v;
      logic        ld, sy, ad;
      clk_sys_in = 1'b0; rstn_in = 1'b0; req = '0;
      n_fail = 0; n_compared = 0; lfsr = 32'h8B678AE0;
      repeat (10) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      axi_read(A_CTRL, d, r); check(d, 32'h0000_0000, "ctrl reset");
      axi_read(A_SYNC, d, r); check(d, 32'h0000_0000, "sync cfg reset");
      axi_read(A_DIVH, d, r); check(d, 32'h0000_0000, "divider high reset");
      axi_read(A_STAT, d, r); check(d, 32'h0000_0000, "status reset");
      check(32'(mhz), 32'h0000_0005, "freq at reset");
      $display("test reset done");
      // unmapped place, dropped strobe, read-only status
      axi_write(12'h008, 32'h0000_00FF, 4'hF, r); check(32'(r), 32'h0000_0002, "unmapped write resp");
      axi_read(12'h008, d, r); check(d, 32'h0000_0000, "unmapped read data");
      check(32'(r), 32'h0000_0002, "unmapped read resp");
      axi_write(A_SYNC, 32'h0000_00FF, 4'hE, r); axi_read(A_SYNC, d, r);
      check(d, 32'h0000_0000, "write without low strobe");
      axi_write(A_STAT, 32'h0000_00FF, 4'hF, r); axi_read(A_STAT, d, r);
      check(d, 32'h0000_0000, "status not writable");
      $display("test refusals done");
      // random sets, every corner code first
      for (int i = 0; i < 40; i++) begin
         lfsr = lfsr_next(lfsr); s = lfsr[7:0]; h = lfsr[15:8]; l = lfsr[23:16]; cw = lfsr;
         if (i < 4) begin
            s = {~i[0], i[1:0], (i == 0) ? 5'h1E : (i == 1) ? 5'h1F : (i == 2) ? 5'h1D : 5'h00};
            cw = {lfsr[31:4], 1'b1, i[1:0], i[0]};
            if (i == 0) begin h = 8'h64; l = 8'h2F; end
         end
         axi_write(A_DIVH, {lfsr[31:8], h}, 4'hF, r);
         axi_write(A_DIVL, 32'(l), 4'h1, r);
         axi_write(A_SYNC, 32'(s), 4'hF, r);
         axi_write(A_CTRL, cw, 4'hF, r);
         axi_read(A_DIVH, d, r); check(d, 32'(h), "divider high readback");
         axi_read(A_DIVL, d, r); check(d, 32'(l), "divider low readback");
         axi_read(A_CTRL, d, r); check(d, 32'(cw[3:0]), "ctrl readback");
         ld = cw[3]; ad = cw[0]; sy = ld & s[7]; c = cw[7:0];
         v = ld ? exp_volts(s[4:0]) : 6'h00;
         check(32'(sync), 32'(sy), "sync enable");
         check(32'(dith), ld ? 32'(s[6:5]) : 32'h0, "dither bits");
         check(32'(vstart), ad ? 32'(v) : 32'h0, "start volts");
         check(32'(vfixed), ad ? 32'h0 : 32'(v), "fixed volts");
         check(32'(div), sy ? 32'({h, l[7:3]}) : 32'h0, "pll divider");
         if (i == 0) check(32'(div), 32'h0000_0C85, "example divider");
         check(32'({ready, adapt, sel}), 32'({ld, ld & ad, c[2:1]}), "ready adapt select");
         check(32'(mhz), 32'(6'h05 << c[2:1]), "pll frequency");
         axi_read(A_STAT, st, r);
         check(st, 32'({ld, sy ? {h, l[7:3]} : 13'h0000, ld & ad, sy, v}), "status word");
      end
      $display("test random done");
      summarize();
   end
endmodule : backlight_boost_sync_config_tb
